// >>> rtl/ocl_pkg.sv
package ocl_pkg;

  // register indices
  localparam logic [7:0] ADDR_UPPER    = 8'hC8;
  localparam logic [7:0] ADDR_LOWER    = 8'hC9;
  localparam logic [7:0] ADDR_SPARE_CA = 8'hCA;
  localparam logic [7:0] ADDR_SPARE_CB = 8'hCB;
  localparam logic [7:0] ADDR_SPARE_CC = 8'hCC;

  // reset values and writable masks
  localparam logic [15:0] UPPER_RESET    = 16'h7FFF;
  localparam logic [15:0] LOWER_RESET    = 16'h8000;
  localparam logic [15:0] SPARE_CA_RESET = 16'h5555;
  localparam logic [15:0] SPARE_CB_RESET = 16'h0010;
  localparam logic [15:0] SPARE_CC_RESET = 16'h0000;
  localparam logic [15:0] SPARE_CA_MASK  = 16'hFFFF;
  localparam logic [15:0] SPARE_CB_MASK  = 16'h07F0;
  localparam logic [15:0] SPARE_CC_MASK  = 16'hC703;
  localparam logic [15:0] UPPER_OFF      = 16'h7FFF;
  localparam logic [15:0] LOWER_OFF      = 16'h8000;
  localparam logic [7:0]  CNT_MAX        = 8'hFF;

  typedef struct packed {
    logic [15:0] upper_limit;
    logic [15:0] lower_limit;
    logic [15:0] spare_ca;
    logic [15:0] spare_cb;
    logic [15:0] spare_cc;
    logic [7:0]  upper_cnt;
    logic [7:0]  lower_cnt;
    logic        upper_event;
    logic        lower_event;
    logic        fault;
    logic [15:0] rd_data;
  } state_t;

  localparam state_t ST_RESET = '{
    upper_limit: UPPER_RESET, lower_limit: LOWER_RESET,
    spare_ca: SPARE_CA_RESET, spare_cb: SPARE_CB_RESET, spare_cc: SPARE_CC_RESET,
    upper_cnt: 8'h00, lower_cnt: 8'h00, upper_event: 1'b0, lower_event: 1'b0,
    fault: 1'b0, rd_data: 16'h0000};

  // conversions needed before a trip, per deglitch code
  function automatic logic [7:0] deglitch_need(input logic [4:0] code);
    case (code)
      5'h0A:   deglitch_need = 8'h0C;
      5'h0B:   deglitch_need = 8'h0E;
      5'h0C:   deglitch_need = 8'h10;
      5'h0D:   deglitch_need = 8'h12;
      5'h0E:   deglitch_need = 8'h14;
      5'h0F:   deglitch_need = 8'h18;
      5'h10:   deglitch_need = 8'h1C;
      5'h11:   deglitch_need = 8'h20;
      5'h12:   deglitch_need = 8'h28;
      5'h13:   deglitch_need = 8'h30;
      5'h14:   deglitch_need = 8'h38;
      5'h15:   deglitch_need = 8'h40;
      5'h16:   deglitch_need = 8'h48;
      5'h17:   deglitch_need = 8'h50;
      5'h18:   deglitch_need = 8'h58;
      5'h19:   deglitch_need = 8'h60;
      5'h1A:   deglitch_need = 8'h68;
      5'h1B:   deglitch_need = 8'h70;
      5'h1C:   deglitch_need = 8'h78;
      5'h1D:   deglitch_need = 8'h80;
      5'h1E:   deglitch_need = 8'h80;
      5'h1F:   deglitch_need = 8'h80;
      default: deglitch_need = {3'b000, code} + 8'h01;
    endcase
  endfunction : deglitch_need

endpackage : ocl_pkg

// >>> rtl/overcurrent_threshold_regs.sv
`timescale 1ns/1ns
module overcurrent_threshold_regs
  import ocl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rd_data,
  input  wire logic        fault_b_compare_enable,
  input  wire logic [4:0]  fault_b_deglitch_count,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_value,
  output logic             fault_b_upper_event,
  output logic             fault_b_lower_event,
  output logic             fault_b_fault
);

  state_t st_reg;
  state_t st_next;

  logic [7:0] need;
  logic       upper_beyond;
  logic       lower_beyond;
  logic [7:0] upper_inc;
  logic [7:0] lower_inc;

  // raw code compare; both sides share one step size, so no scaling
  assign need         = deglitch_need(fault_b_deglitch_count);
  assign upper_beyond = (st_reg.upper_limit != UPPER_OFF) &&
                        ($signed(sample_value) > $signed(st_reg.upper_limit));
  assign lower_beyond = (st_reg.lower_limit != LOWER_OFF) &&
                        ($signed(sample_value) < $signed(st_reg.lower_limit));
  // saturate so a long excursion cannot wrap and drop the event
  assign upper_inc    = (st_reg.upper_cnt == CNT_MAX) ? CNT_MAX : st_reg.upper_cnt + 8'h01;
  assign lower_inc    = (st_reg.lower_cnt == CNT_MAX) ? CNT_MAX : st_reg.lower_cnt + 8'h01;

  // next state: register writes, comparator and read path
  always_comb begin
    st_next = st_reg;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_UPPER:    st_next.upper_limit = reg_wdata;
        ADDR_LOWER:    st_next.lower_limit = reg_wdata;
        ADDR_SPARE_CA: st_next.spare_ca    = reg_wdata & SPARE_CA_MASK;
        ADDR_SPARE_CB: st_next.spare_cb    = reg_wdata & SPARE_CB_MASK;
        ADDR_SPARE_CC: st_next.spare_cc    = reg_wdata & SPARE_CC_MASK;
        default:       st_next.spare_ca    = st_reg.spare_ca;
      endcase
    end
    // comparator only evaluates on a fresh conversion while enabled
    if (!fault_b_compare_enable) begin
      st_next.upper_cnt   = 8'h00;
      st_next.lower_cnt   = 8'h00;
      st_next.upper_event = 1'b0;
      st_next.lower_event = 1'b0;
    end else if (sample_valid) begin
      st_next.upper_cnt   = upper_beyond ? upper_inc : 8'h00;
      st_next.upper_event = upper_beyond && (upper_inc >= need);
      st_next.lower_cnt   = lower_beyond ? lower_inc : 8'h00;
      st_next.lower_event = lower_beyond && (lower_inc >= need);
    end
    st_next.fault = st_next.upper_event | st_next.lower_event;
    // read data follows the address one cycle later; spares readable for the crc
    case (reg_addr)
      ADDR_UPPER:    st_next.rd_data = st_reg.upper_limit;
      ADDR_LOWER:    st_next.rd_data = st_reg.lower_limit;
      ADDR_SPARE_CA: st_next.rd_data = st_reg.spare_ca;
      ADDR_SPARE_CB: st_next.rd_data = st_reg.spare_cb & SPARE_CB_MASK;
      ADDR_SPARE_CC: st_next.rd_data = st_reg.spare_cc & SPARE_CC_MASK;
      default:       st_next.rd_data = 16'h0000;
    endcase
  end

  // single state register, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rd_data         = st_reg.rd_data;
  assign fault_b_upper_event = st_reg.upper_event;
  assign fault_b_lower_event = st_reg.lower_event;
  assign fault_b_fault       = st_reg.fault;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence upper_trip_s;
    fault_b_compare_enable && sample_valid && upper_beyond && (upper_inc >= need);
  endsequence
  sequence lower_trip_s;
    fault_b_compare_enable && sample_valid && lower_beyond && (lower_inc >= need);
  endsequence
  sequence upper_inside_s;
    sample_valid && ($signed(sample_value) <= $signed(st_reg.upper_limit));
  endsequence

  upper_reset_a: assert property (disable iff (1'b0) !rst_n |=> st_reg.upper_limit == 16'h7FFF)
    else $error("upper limit not at reset value");
  lower_reset_a: assert property (disable iff (1'b0) !rst_n |=> st_reg.lower_limit == 16'h8000)
    else $error("lower limit not at reset value");
  upper_trip_a: assert property (upper_trip_s |=> fault_b_upper_event && fault_b_fault)
    else $error("upper event missing after trip");
  lower_trip_a: assert property (lower_trip_s |=> fault_b_lower_event && fault_b_fault)
    else $error("lower event missing after trip");
  upper_off_a: assert property (sample_valid && st_reg.upper_limit == 16'h7FFF |=> !fault_b_upper_event)
    else $error("upper event with detection off");
  lower_off_a: assert property (sample_valid && st_reg.lower_limit == 16'h8000 |=> !fault_b_lower_event)
    else $error("lower event with detection off");
  count_restart_a: assert property (upper_inside_s |=> st_reg.upper_cnt == 8'h00 && !fault_b_upper_event)
    else $error("upper count not restarted");
  first_hit_a: assert property (fault_b_compare_enable && sample_valid && upper_beyond
                                && st_reg.upper_cnt == 8'h00 && need > 8'h01 |=> !fault_b_upper_event)
    else $error("upper event tripped early");
  compare_off_a: assert property (!fault_b_compare_enable |=> !fault_b_fault)
    else $error("fault while comparator disabled");
  fault_or_a: assert property (fault_b_fault == (fault_b_upper_event || fault_b_lower_event))
    else $error("fault not or of events");
  spare_ca_write_a: assert property (reg_wr && reg_addr == ADDR_SPARE_CA ##1 reg_addr == ADDR_SPARE_CA
                                     |=> reg_rd_data == $past(reg_wdata, 2))
    else $error("spare CA readback wrong");
  spare_cb_zero_a: assert property (reg_addr == ADDR_SPARE_CB |=> reg_rd_data[15:11] == 5'h00
                                    && reg_rd_data[3:0] == 4'h0)
    else $error("spare CB read-only bits not zero");
  spare_cc_zero_a: assert property (reg_addr == ADDR_SPARE_CC |=> reg_rd_data[13:11] == 3'h0
                                    && reg_rd_data[7:2] == 6'h00)
    else $error("spare CC read-only bits not zero");

endmodule : overcurrent_threshold_regs

// >>> test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import ocl_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, cmp_en = 1'b0, smp_vld = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [4:0]  dg = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, smp_val = 16'h0000, reg_rd_data, v;
  logic [15:0] m [5] = '{UPPER_RESET, LOWER_RESET, SPARE_CA_RESET, SPARE_CB_RESET, SPARE_CC_RESET};
  logic [15:0] msk [5] = '{16'hFFFF, 16'hFFFF, SPARE_CA_MASK, SPARE_CB_MASK, SPARE_CC_MASK};
  logic        ue, le, flt, eu = 1'b0, el = 1'b0;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, cu = 0, cl = 0, r;

  overcurrent_threshold_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .fault_b_compare_enable(cmp_en),
    .fault_b_deglitch_count(dg), .sample_valid(smp_vld), .sample_value(smp_val),
    .fault_b_upper_event(ue), .fault_b_lower_event(le), .fault_b_fault(flt));

  // 25 MHz clock; the ceiling is generous against a stuck run
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk_reg(input logic [7:0] a, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH reg_rd_data at %h expected %h seen %h", a, e, g);
    end
  endtask : chk_reg

  task automatic chk_evt(input logic [2:0] e, input logic [2:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH upper_lower_fault expected %b seen %b", e, g);
    end
  endtask : chk_evt

  // conversions needed per deglitch code
  function automatic int need(input logic [4:0] c);
    if (c < 10) return c + 1;
    if (c < 14) return 12 + 2 * (c - 10);
    if (c < 18) return 20 + 4 * (c - 14);
    if (c < 30) return 40 + 8 * (c - 18);
    return 128;
  endfunction : need

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (a >= ADDR_UPPER && a <= ADDR_SPARE_CC) m[a - ADDR_UPPER] = d & msk[a - ADDR_UPPER];
  endtask : wr

  // unmapped indices read zero
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    @(posedge ref_clk);
    #1 chk_reg(a, (a >= ADDR_UPPER && a <= ADDR_SPARE_CC) ? m[a - ADDR_UPPER] : 16'h0000, reg_rd_data);
  endtask : rd

  // one conversion; a disabled sample also reloads the deglitch code
  task automatic smp(input logic [15:0] x, input logic en, input logic [4:0] c);
    @(posedge ref_clk);
    smp_vld <= 1'b1;
    smp_val <= x;
    cmp_en  <= en;
    dg      <= c;
    @(posedge ref_clk);
    smp_vld <= 1'b0;
    cu = (en && m[0] != 16'h7FFF && $signed(x) > $signed(m[0])) ? ((cu < 255) ? cu + 1 : 255) : 0;
    cl = (en && m[1] != 16'h8000 && $signed(x) < $signed(m[1])) ? ((cl < 255) ? cl + 1 : 255) : 0;
    eu = en && cu >= need(c);
    el = en && cl >= need(c);
    #1 chk_evt({eu, el, eu | el}, {ue, le, flt});
  endtask : smp

  initial begin
    void'($urandom(32'hdb10_970e));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ADDR_UPPER + 8'(i));
    for (int i = 0; i < 7; i++) begin
      wr(8'hC7 + 8'(i), (i % 2) ? 16'hFFFF : 16'(($urandom)));
      rd(8'hC7 + 8'(i));
    end
    wr(ADDR_UPPER, 16'h7FFF);
    wr(ADDR_LOWER, 16'h8000);
    smp(16'h7FFF, 1'b1, 5'h00);
    smp(16'h8000, 1'b1, 5'h00);
    wr(ADDR_UPPER, 16'h0100);
    wr(ADDR_LOWER, 16'hFF00);
    smp(16'h0100, 1'b1, 5'h00);
    smp(16'h0101, 1'b1, 5'h00);
    wr(ADDR_SPARE_CA, 16'hA5A5);
    #1 chk_evt({eu, el, eu | el}, {ue, le, flt});
    smp(16'hFF00, 1'b1, 5'h00);
    smp(16'hFEFF, 1'b1, 5'h00);
    smp(16'hFEFF, 1'b0, 5'h15);
    for (int i = 0; i < 128; i++) smp((i == 63) ? 16'h0000 : 16'h7000, 1'b1, 5'h15);
    for (int i = 0; i < 400; i++) begin
      r = $urandom_range(0, 9);
      if (r == 0) begin
        wr(ADDR_UPPER, 16'($urandom_range(0, 16'h0400)));
        wr(ADDR_LOWER, 16'hFC00 + 16'($urandom_range(0, 16'h0400)));
        rd(8'($urandom_range(16'hC6, 16'hCE)));
      end else if (r == 1) smp(16'($urandom), 1'b0, 5'($urandom_range(0, 4)));
      else begin
        case ($urandom_range(0, 5))
          0, 1: v = m[0] + 16'h0001;
          2: v = m[0];
          3: v = m[1] - 16'h0001;
          4: v = m[1];
          default: v = 16'($urandom);
        endcase
        smp(v, 1'b1, dg);
      end
    end
    stop_test();
  end
endmodule : tb_top
